// ### inc/trs_pkg.sv
// Purpose: Shared constants and types for trigger routing and threshold select
// Assumes: Single board clock domain, plain control ports
// Notes: Selector codes, field widths and reset values live here
package trs_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int TRS_BUS_LINES = 7;
   localparam int TRS_TIMING_SIGS = 8;
   localparam int TRS_BRD_SIGS = 4;
   localparam int TRS_BUS_SEL_W = 4;
   localparam int TRS_BRD_SEL_W = 3;
   localparam int TRS_MODE_W = 3;
   localparam int TRS_DAC8_W = 8;
   localparam int TRS_DAC12_W = 12;

   // ----------------------------------------------------------------------
   // Selector codes
   // ----------------------------------------------------------------------
   // Bus selector: 0..7 timing signals, 8..11 board signals
   localparam logic [TRS_BUS_SEL_W-1:0] TRS_BUS_SEL_BRD0 = 4'h8;
   localparam logic [TRS_BUS_SEL_W-1:0] TRS_BUS_SEL_MAX = 4'hb;
   // Board selector: 0..6 bus lines, 7 start or stop pulse
   localparam logic [TRS_BRD_SEL_W-1:0] TRS_BRD_SEL_PULSE = 3'h7;
   localparam logic [TRS_MODE_W-1:0] TRS_MODE_LOW_HYST = 3'h6;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [TRS_BUS_SEL_W-1:0] TRS_BUS_SEL_RST = 4'h0;
   localparam logic [TRS_BRD_SEL_W-1:0] TRS_BRD_SEL_RST = 3'h0;
   localparam logic [TRS_MODE_W-1:0] TRS_MODE_RST = 3'h0;
   localparam logic [TRS_DAC12_W-1:0] TRS_DAC_RST = 12'h000;

   typedef enum logic [1:0] {
      TRS_TH_OFF = 2'b00,
      TRS_TH_ARMED = 2'b01,
      TRS_TH_LOWHYST = 2'b10
   } trs_th_state_e;

   typedef struct packed {
      logic src_sel_gain;
      logic pin_connect;
      logic th_enable;
      logic [TRS_MODE_W-1:0] th_mode;
      logic dac_is_12bit;
   } trs_ctrl_s;

endpackage

// ### core/trs_bus_sel.sv
// Purpose: One 12-input selector driving one shared trigger bus line
// Assumes: Select code held in a register by the caller
// Notes: Codes above the last input drive low
module trs_bus_sel
   import trs_pkg::*;
(
   // Sources
   input wire logic [TRS_TIMING_SIGS-1:0] timing_sig,
   input wire logic [TRS_BRD_SIGS-1:0] board_sig,
   // Control
   input wire logic [TRS_BUS_SEL_W-1:0] sel,
   // Output
   output logic line_out
);

   logic [11:0] srcs;

   assign srcs = {board_sig, timing_sig};

   always_comb begin
      if (sel <= TRS_BUS_SEL_MAX) begin
         line_out = srcs[sel];
      end else begin
         line_out = 1'b0;
      end
   end

endmodule

// ### core/trs_top.sv
// Purpose: Trigger routing, generated trigger and threshold trigger front end
// Assumes: Host loads settings with a write strobe; inputs synchronous
// Notes: Threshold DAC codes are inverted offsets: code 0 is highest level
//
// How it works
// - Each bus line has 12-input selector
// - Each board signal has 8-input selector
// - Only board signal 0 connects, others idle
// - Generated trigger is convert AND config bit
// - Source bit picks gain output or pin
// - Connect bit ties pin to programmable input
// - 8-bit code 0x00 is positive full scale
// - 12-bit code 0x000 is positive full scale
// - Comparators high when input above threshold
// - Thresholds from two calibration DAC channels
// - Threshold enable takes over pin slot
// - Mode 6 with enable selects low hysteresis
module trs_top
   import trs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Host settings
   input wire logic cfg_we,
   input wire logic [TRS_BUS_LINES*TRS_BUS_SEL_W-1:0] cfg_bus_sel,
   input wire logic [TRS_BRD_SIGS*TRS_BRD_SEL_W-1:0] cfg_brd_sel,
   input wire logic cfg_brd_pulse_stop,
   input wire trs_ctrl_s cfg_ctrl,
   input wire logic cfg_trig_on_convert,
   input wire logic dac_we,
   input wire logic [3:0] dac_chan,
   input wire logic [TRS_DAC12_W-1:0] dac_code,
   // Internal timing
   input wire logic [TRS_TIMING_SIGS-1:0] timing_sig,
   input wire logic convert_pulse,
   input wire logic acq_start_pulse,
   input wire logic acq_stop_pulse,
   // Shared trigger bus lines
   input wire logic [TRS_BUS_LINES-1:0] shared_trigger_bus_i,
   output logic [TRS_BUS_LINES-1:0] shared_trigger_bus_o,
   output logic [TRS_BUS_LINES-1:0] shared_trigger_bus_oe,
   input wire logic [TRS_BUS_LINES-1:0] cfg_bus_drive,
   // Analog front end, sampled as digital magnitude codes
   input wire logic [TRS_DAC12_W-1:0] gain_amplifier_output,
   input wire logic [TRS_DAC12_W-1:0] external_trigger_pin,
   input wire logic external_trigger_pin_dig,
   // Outputs
   output logic generated_trigger_0,
   output logic [TRS_BRD_SIGS-1:0] board_sig,
   output logic programmable_input_0,
   output logic [1:0] threshold_trig,
   output logic low_hyst_mode,
   output logic [TRS_DAC12_W-1:0] thresh_hi_level,
   output logic [TRS_DAC12_W-1:0] thresh_lo_level,
   output trs_th_state_e th_state
);

   // ----------------------------------------------------------------------
   // Setting registers
   // ----------------------------------------------------------------------
   logic [TRS_BUS_LINES*TRS_BUS_SEL_W-1:0] bus_sel_q;
   logic [TRS_BRD_SIGS*TRS_BRD_SEL_W-1:0] brd_sel_q;
   logic brd_pulse_stop_q;
   logic [TRS_BUS_LINES-1:0] bus_drive_q;
   trs_ctrl_s ctrl_q;
   logic trig_on_convert_bit;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bus_sel_q <= '0;
         brd_sel_q <= '0;
         brd_pulse_stop_q <= 1'b0;
         bus_drive_q <= '0;
         ctrl_q <= '0;
         trig_on_convert_bit <= 1'b0;
      end else if (cfg_we) begin
         bus_sel_q <= cfg_bus_sel;
         brd_sel_q <= cfg_brd_sel;
         brd_pulse_stop_q <= cfg_brd_pulse_stop;
         bus_drive_q <= cfg_bus_drive;
         ctrl_q <= cfg_ctrl;
         trig_on_convert_bit <= cfg_trig_on_convert;
      end
   end

   // ----------------------------------------------------------------------
   // Threshold DAC channels
   // ----------------------------------------------------------------------
   logic [TRS_DAC12_W-1:0] cal_ch11_q, cal_ch12_q, cal_ch0_q, cal_ch1_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cal_ch11_q <= TRS_DAC_RST;
         cal_ch12_q <= TRS_DAC_RST;
         cal_ch0_q <= TRS_DAC_RST;
         cal_ch1_q <= TRS_DAC_RST;
      end else if (dac_we) begin
         case (dac_chan)
            4'hb: cal_ch11_q <= {4'h0, dac_code[TRS_DAC8_W-1:0]};
            4'hc: cal_ch12_q <= {4'h0, dac_code[TRS_DAC8_W-1:0]};
            4'h0: cal_ch0_q <= dac_code;
            4'h1: cal_ch1_q <= dac_code;
            default: ;
         endcase
      end
   end

   // Full scale minus code gives a level rising as the code falls
   function automatic logic [TRS_DAC12_W-1:0] trs_level(
      input logic [TRS_DAC12_W-1:0] code, input logic wide);
      if (wide) begin
         trs_level = 12'hfff - code;
      end else begin
         trs_level = {8'hff - code[TRS_DAC8_W-1:0], 4'hf};
      end
   endfunction

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         thresh_hi_level <= 12'hfff;
         thresh_lo_level <= 12'hfff;
      end else if (ctrl_q.dac_is_12bit) begin
         thresh_hi_level <= trs_level(cal_ch0_q, 1'b1);
         thresh_lo_level <= trs_level(cal_ch1_q, 1'b1);
      end else begin
         thresh_hi_level <= trs_level(cal_ch11_q, 1'b0);
         thresh_lo_level <= trs_level(cal_ch12_q, 1'b0);
      end
   end

   // ----------------------------------------------------------------------
   // Comparators
   // ----------------------------------------------------------------------
   logic [TRS_DAC12_W-1:0] th_input;

   assign th_input = ctrl_q.src_sel_gain ? gain_amplifier_output
                                         : external_trigger_pin;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         threshold_trig <= 2'b00;
      end else begin
         threshold_trig[0] <= th_input > thresh_hi_level;
         threshold_trig[1] <= th_input > thresh_lo_level;
      end
   end

   // ----------------------------------------------------------------------
   // Threshold mode state
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         th_state <= TRS_TH_OFF;
      end else begin
         case (th_state)
            TRS_TH_OFF,
            TRS_TH_ARMED,
            TRS_TH_LOWHYST: begin
               if (!ctrl_q.th_enable) begin
                  th_state <= TRS_TH_OFF;
               end else if (ctrl_q.th_mode == TRS_MODE_LOW_HYST) begin
                  th_state <= TRS_TH_LOWHYST;
               end else begin
                  th_state <= TRS_TH_ARMED;
               end
            end
            default: th_state <= TRS_TH_OFF;
         endcase
      end
   end

   assign low_hyst_mode = (th_state == TRS_TH_LOWHYST);

   // ----------------------------------------------------------------------
   // Programmable input 0 slot
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         programmable_input_0 <= 1'b0;
      end else if (ctrl_q.th_enable) begin
         programmable_input_0 <= threshold_trig[0];
      end else if (ctrl_q.pin_connect) begin
         programmable_input_0 <= external_trigger_pin_dig;
      end else begin
         programmable_input_0 <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Generated trigger and board signals
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         generated_trigger_0 <= 1'b0;
      end else begin
         generated_trigger_0 <= convert_pulse & trig_on_convert_bit;
      end
   end

   logic [TRS_BRD_SIGS-1:0] brd_sel_out;
   logic acq_pulse;

   assign acq_pulse = brd_pulse_stop_q ? acq_stop_pulse : acq_start_pulse;

   genvar gb;
   generate
      for (gb = 0; gb < TRS_BRD_SIGS; gb++) begin : g_brd
         logic [TRS_BRD_SEL_W-1:0] s;
         assign s = brd_sel_q[gb*TRS_BRD_SEL_W +: TRS_BRD_SEL_W];
         assign brd_sel_out[gb] = (s == TRS_BRD_SEL_PULSE) ? acq_pulse
                                   : shared_trigger_bus_i[s];
      end
   endgenerate

   // Board signal 0 carries the generated trigger; the selected bus
   // value has no load beyond the selector itself
   assign board_sig = {3'b000, generated_trigger_0 | 1'b0};

   // ----------------------------------------------------------------------
   // Shared trigger bus drivers
   // ----------------------------------------------------------------------
   genvar gl;
   generate
      for (gl = 0; gl < TRS_BUS_LINES; gl++) begin : g_bus
         trs_bus_sel u_sel (
            .timing_sig(timing_sig),
            .board_sig(board_sig),
            .sel(bus_sel_q[gl*TRS_BUS_SEL_W +: TRS_BUS_SEL_W]),
            .line_out(shared_trigger_bus_o[gl])
         );
      end
   endgenerate

   assign shared_trigger_bus_oe = bus_drive_q;

endmodule

// ### tb/trs_top_properties.sv
// Purpose: Port checker for trs_top
// Assumes: One clock domain; settings load on cfg_we
// Notes: Helper copies track the loaded settings
module trs_top_properties
   import trs_pkg::*;
(
   // Clock, reset and settings
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cfg_we,
   input wire logic [27:0] cfg_bus_sel,
   input wire trs_ctrl_s cfg_ctrl,
   input wire logic cfg_trig_on_convert,
   // Sources
   input wire logic [7:0] timing_sig,
   input wire logic convert_pulse,
   input wire logic external_trigger_pin_dig,
   input wire logic [11:0] gain_amplifier_output,
   input wire logic [11:0] external_trigger_pin,
   // Outputs
   input wire logic [6:0] shared_trigger_bus_o,
   input wire logic generated_trigger_0,
   input wire logic [3:0] board_sig,
   input wire logic programmable_input_0,
   input wire logic [1:0] threshold_trig,
   input wire logic low_hyst_mode,
   input wire logic [11:0] thresh_hi_level,
   input wire logic [11:0] thresh_lo_level,
   input wire trs_th_state_e th_state
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------------
   logic [27:0] sel_q;
   logic toc_q;
   trs_ctrl_s ctl_q;
   logic [6:0] exp_bus;
   logic [11:0] src;
   function automatic logic pick(logic [3:0] c, logic [7:0] t, logic [3:0] b);
      return c < 4'h8 ? t[c[2:0]] : (c < 4'hc ? b[c[1:0]] : 1'b0);
   endfunction
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sel_q <= '0;
         toc_q <= 1'b0;
         ctl_q <= '0;
      end else if (cfg_we) begin
         sel_q <= cfg_bus_sel;
         toc_q <= cfg_trig_on_convert;
         ctl_q <= cfg_ctrl;
      end
   end
   always_comb begin
      for (int n = 0; n < 7; n++) begin
         exp_bus[n] = pick(sel_q[4*n+:4], timing_sig, board_sig);
      end
   end
   assign src = ctl_q.src_sel_gain ? gain_amplifier_output
                                   : external_trigger_pin;
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_iso;
      !ctl_q.pin_connect && !ctl_q.th_enable;
   endsequence
   sequence s_slot;
      ctl_q.pin_connect && ctl_q.th_enable;
   endsequence
   a_bus_route: assert property (shared_trigger_bus_o == exp_bus)
      else $error("bus line value wrong");
   a_board_map: assert property (board_sig == {3'h0, generated_trigger_0})
      else $error("board signal map wrong");
   a_gen_and: assert property (1'b1 |=>
      generated_trigger_0 == $past(convert_pulse && toc_q))
      else $error("generated trigger wrong");
   a_pin_on: assert property (ctl_q.pin_connect && !ctl_q.th_enable |=>
      programmable_input_0 == $past(external_trigger_pin_dig))
      else $error("pin not passed");
   a_pin_iso: assert property (s_iso |=> !programmable_input_0)
      else $error("pin not isolated");
   a_thr_slot: assert property (s_slot |=>
      programmable_input_0 == $past(threshold_trig[0]))
      else $error("slot not taken over");
   a_cmp_out: assert property (1'b1 |=> threshold_trig ==
      $past({src > thresh_lo_level, src > thresh_hi_level}))
      else $error("comparator wrong");
   a_hyst_on: assert property (ctl_q.th_enable &&
      ctl_q.th_mode == TRS_MODE_LOW_HYST |=> th_state == TRS_TH_LOWHYST)
      else $error("low hysteresis not set");
   a_thr_off: assert property (!ctl_q.th_enable |=> th_state == TRS_TH_OFF)
      else $error("threshold state not off");
   a_hyst_flag: assert property (1'b1 |=> low_hyst_mode ==
      $past(ctl_q.th_enable && ctl_q.th_mode == TRS_MODE_LOW_HYST))
      else $error("hysteresis flag wrong");
endmodule

bind trs_top trs_top_properties trs_top_properties_inst (.*);

// ### tb/trs_bus_partner.sv
// Purpose: Other boards on the shared trigger bus lines
// Assumes: No pull on the lines
// Notes: Device drive wins a clash; idle lines toggle every cycle
module trs_bus_partner
(
   // Clock
   input wire logic clk_sys,
   // Device and peer drive
   input wire logic [6:0] dev_o,
   input wire logic [6:0] dev_oe,
   input wire logic [6:0] peer_val,
   input wire logic [6:0] peer_oe,
   // Resolved lines
   output logic [6:0] bus_lvl
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] float_q = 7'h55;
   always_ff @(posedge clk_sys) begin
      float_q <= ~float_q;
   end
   assign bus_lvl = (dev_oe & dev_o) | (~dev_oe & peer_oe & peer_val)
                  | (~dev_oe & ~peer_oe & float_q);
endmodule

// ### tb/trs_top_tb.sv
// Purpose: Directed bench for trs_top
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Settings settle four cycles before each compare
module trs_top_tb
   import trs_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic resetn, cfg_we, dac_we, toc, conv, pin_dig, gen, pi0, hyst;
   logic [27:0] bsel;
   logic [11:0] dcode, gain, pin, hi, lo;
   logic [7:0] tsig;
   logic [6:0] drv, peer_v, peer_oe, bus_i, bus_o, bus_oe;
   logic [3:0] dchan, bsig;
   logic [1:0] ttrig;
   trs_ctrl_s ctl;
   trs_th_state_e st;
   int failures, check_count;
   always #2 clk_sys = ~clk_sys;
   trs_top trs_top_inst (.clk_sys(clk_sys), .resetn(resetn),
      .cfg_we(cfg_we), .cfg_bus_sel(bsel), .cfg_brd_sel(12'h000),
      .cfg_brd_pulse_stop(1'b0), .cfg_ctrl(ctl),
      .cfg_trig_on_convert(toc), .dac_we(dac_we), .dac_chan(dchan),
      .dac_code(dcode), .timing_sig(tsig), .convert_pulse(conv),
      .acq_start_pulse(1'b0), .acq_stop_pulse(1'b0),
      .shared_trigger_bus_i(bus_i), .shared_trigger_bus_o(bus_o),
      .shared_trigger_bus_oe(bus_oe), .cfg_bus_drive(drv),
      .gain_amplifier_output(gain), .external_trigger_pin(pin),
      .external_trigger_pin_dig(pin_dig), .generated_trigger_0(gen),
      .board_sig(bsig), .programmable_input_0(pi0),
      .threshold_trig(ttrig), .low_hyst_mode(hyst),
      .thresh_hi_level(hi), .thresh_lo_level(lo), .th_state(st));
   trs_bus_partner trs_bus_partner_inst (.clk_sys(clk_sys), .dev_o(bus_o),
      .dev_oe(bus_oe), .peer_val(peer_v), .peer_oe(peer_oe),
      .bus_lvl(bus_i));
   task automatic chk(input logic [27:0] got, input logic [27:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic load();
      cfg_we = 1'b1;
      tick(1);
      cfg_we = 1'b0;
      tick(4);
   endtask
   task automatic dac(input logic [3:0] c, input logic [11:0] v);
      dac_we = 1'b1;
      dchan = c;
      dcode = v;
      tick(1);
      dac_we = 1'b0;
      tick(4);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      end_sim();
   end
   initial begin
      {resetn, cfg_we, dac_we, toc, conv, pin_dig} = '0;
      {bsel, dchan, dcode, gain, pin, tsig, drv} = '0;
      {ctl, failures, check_count} = '0;
      peer_v = 7'h2a;
      peer_oe = 7'h0f;
      repeat (8) @(posedge clk_sys);
      #1 resetn = 1'b1;
      tick(1);
      chk({hi, lo}, 28'h0ffffff);
      chk({gen, pi0, ttrig, bsig, bus_oe, bus_o, st, hyst}, '0);
      toc = 1'b1;
      conv = 1'b1;
      drv = 7'h55;
      for (int c = 0; c < 16; c++) begin
         bsel = {7{c[3:0]}};
         tsig = (c < 8) ? 8'h01 << c : 8'hff;
         load();
         chk(bus_o, (c < 9) ? 7'h7f : 7'h00);
      end
      chk(bsig, 4'h1);
      chk(bus_oe, 7'h55);
      conv = 1'b0;
      tick(3);
      chk(gen, 1'b0);
      toc = 1'b0;
      conv = 1'b1;
      load();
      chk(gen, 1'b0);
      ctl.pin_connect = 1'b1;
      pin_dig = 1'b1;
      load();
      chk(pi0, 1'b1);
      pin_dig = 1'b0;
      tick(2);
      chk(pi0, 1'b0);
      ctl.pin_connect = 1'b0;
      pin_dig = 1'b1;
      load();
      chk(pi0, 1'b0);
      ctl.dac_is_12bit = 1'b1;
      ctl.src_sel_gain = 1'b1;
      gain = 12'h800;
      pin = 12'hfff;
      load();
      dac(4'h0, 12'h400);
      dac(4'h1, 12'hc00);
      chk({hi, lo}, 28'h0bff3ff);
      chk(ttrig, 2'b10);
      ctl.src_sel_gain = 1'b0;
      load();
      chk(ttrig, 2'b11);
      dac(4'h0, 12'h000);
      dac(4'h1, 12'hfff);
      chk({hi, lo, ttrig}, 28'h3ffc002);
      ctl.dac_is_12bit = 1'b0;
      load();
      dac(4'hb, 12'h080);
      dac(4'h0, 12'h080);
      dac(4'hc, 12'h0a0);
      dac(4'h5, 12'h123);
      chk({hi, lo}, 28'h07ff5ff);
      dac(4'hc, 12'h0ff);
      dac(4'hb, 12'h0ff);
      dac(4'h0, 12'h0ff);
      chk({hi, lo}, 28'h000f00f);
      ctl.th_enable = 1'b1;
      ctl.pin_connect = 1'b1;
      ctl.th_mode = TRS_MODE_LOW_HYST;
      pin_dig = 1'b0;
      load();
      chk({st, hyst}, {TRS_TH_LOWHYST, 1'b1});
      chk(pi0, 1'b1);
      ctl.th_mode = 3'h5;
      load();
      chk({st, hyst}, {TRS_TH_ARMED, 1'b0});
      ctl.th_enable = 1'b0;
      ctl.th_mode = TRS_MODE_LOW_HYST;
      load();
      chk({st, hyst}, {TRS_TH_OFF, 1'b0});
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(1);
      chk({hi, lo, pi0, gen}, 28'h3fffffc);
      end_sim();
   end
endmodule
